// ### design/event_status_pkg.sv
package event_status_pkg;

  localparam logic [7:0] ADDR_STATUS_PRI = 8'h00;
  localparam logic [7:0] ADDR_STATUS_SEC = 8'h01;
  localparam logic [7:0] ADDR_ENABLE_PRI = 8'h02;
  localparam logic [7:0] ADDR_ENABLE_SEC = 8'h03;
  localparam logic [7:0] STATUS_PRI_RESET = 8'h00;
  localparam logic [7:0] STATUS_SEC_RESET = 8'h00;
  localparam logic [7:0] ENABLE_PRI_RESET = 8'h00;
  localparam logic [7:0] ENABLE_SEC_RESET = 8'h00;
  localparam logic [7:0] ENABLE_PRI_WMASK = 8'hFE;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  localparam int IRQ_BIT = 0;
  localparam logic [7:0] PRI_STICKY = 8'hE0;
  localparam logic [7:0] PRI_LEVEL = 8'h1E;

  typedef struct packed {
    logic conv2_overload;
    logic conv1_overload;
    logic charge_complete;
    logic charging_active;
    logic battery_good;
    logic system_supply_good;
    logic adapter_good;
  } primary_src_t;

  typedef struct packed {
    logic [6:0] switch_overload;
    logic conv3_overload;
  } secondary_src_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ### design/event_sync.sv
`timescale 1ns/10ps
module event_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule // event_sync

// ### design/pmu_event_status_mask.sv
`timescale 1ns/10ps
// Notes on behaviour
// - primary status at 0x00: two conv overloads, charge, supplies, irq flag; reset 0
// - read-only secondary status at 0x01: switch 7..1 overloads, conv3 overload
// - primary enable at 0x02, bits 7..1; bit 0 reads zero, unwritable
// - secondary enable at 0x03, all eight bits read/write, reset zero
// - overload flags raise an event only on change to 1
// - overload and charge-complete flags stay 1 until interrupt is cleared
// - enable bit 1 lets its event interrupt; 0 suppresses; all start disabled
// - level status bits interrupt on unmasked change in either direction
// - host writes 0 to flag bit to clear it and release the pin
// - while asserted, open-drain interrupt pin is driven low
// - status contents refresh only when an interrupt occurs
module pmu_event_status_mask
  import event_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire primary_src_t primary_src,
  input wire secondary_src_t secondary_src,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output logic irq_pin_out,
  output logic irq_pin_oe
);

  logic [6:0] pri_sync;
  logic [7:0] sec_sync;
  logic [6:0] pri_prev_q;
  logic [6:0] pri_prev_d;
  logic [7:0] sec_prev_q;
  logic [7:0] sec_prev_d;
  logic [7:0] status_pri_q;
  logic [7:0] status_pri_d;
  logic [7:0] status_sec_q;
  logic [7:0] status_sec_d;
  logic [7:0] enable_pri_q;
  logic [7:0] enable_pri_d;
  logic [7:0] enable_sec_q;
  logic [7:0] enable_sec_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [6:0] pri_event;
  logic [7:0] sec_event;
  logic new_irq;
  logic host_clear;
  logic [6:0] pri_rise;
  logic [6:0] pri_change;
  logic [7:0] sec_rise;
  logic [6:0] pri_hit;
  logic [7:0] sec_hit;
  logic wr_status_pri;
  logic wr_enable_pri;
  logic wr_enable_sec;

  // source pins come from analog monitors, outside this clock
  event_sync #(.W(7)) u_sync_pri (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(primary_src),
    .sync_out(pri_sync)
  );

  event_sync #(.W(8)) u_sync_sec (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(secondary_src),
    .sync_out(sec_sync)
  );

  // edge history: the previous synchronised level of every source
  always_comb begin
    pri_prev_d = pri_sync;
    sec_prev_d = sec_sync;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pri_prev_q <= '0;
      sec_prev_q <= '0;
    end else begin
      pri_prev_q <= pri_prev_d;
      sec_prev_q <= sec_prev_d;
    end
  end

  // edge detection on the synchronised sources only, never on raw pins
  always_comb begin
    pri_rise = pri_sync & ~pri_prev_q;
    pri_change = pri_sync ^ pri_prev_q;
    sec_rise = sec_sync & ~sec_prev_q;
    pri_event = (pri_rise & PRI_STICKY[7:1]) | (pri_change & PRI_LEVEL[7:1]);
    sec_event = sec_rise;
  end

  always_comb begin
    pri_hit = pri_event & enable_pri_q[7:1];
    sec_hit = sec_event & enable_sec_q;
    new_irq = (|pri_hit) || (|sec_hit);
  end

  // write decode; the protocol engine gives one-cycle strobes
  always_comb begin
    wr_status_pri = req.wr && (req.addr == ADDR_STATUS_PRI);
    wr_enable_pri = req.wr && (req.addr == ADDR_ENABLE_PRI);
    wr_enable_sec = req.wr && (req.addr == ADDR_ENABLE_SEC);
    // only a written zero clears; a one is ignored
    host_clear = wr_status_pri && !req.wdata[IRQ_BIT];
  end

  // clear first, then a same-cycle event re-sets the flag
  always_comb begin
    status_pri_d = status_pri_q;
    status_sec_d = status_sec_q;
    if (host_clear) begin
      status_pri_d[IRQ_BIT] = 1'b0;
      status_pri_d = status_pri_d & ~PRI_STICKY;
      status_sec_d = 8'h00;
    end
    if (new_irq) begin
      status_pri_d[7:5] = status_pri_d[7:5] | pri_sync[6:4];
      status_pri_d[4:1] = pri_sync[3:0];
      status_sec_d = status_sec_d | sec_sync;
      status_pri_d[IRQ_BIT] = 1'b1;
    end
  end

  always_comb begin
    enable_pri_d = enable_pri_q;
    enable_sec_d = enable_sec_q;
    if (wr_enable_pri) begin
      enable_pri_d = req.wdata & ENABLE_PRI_WMASK;
    end
    if (wr_enable_sec) begin
      enable_sec_d = req.wdata;
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_STATUS_PRI: rdata_d = status_pri_q;
        ADDR_STATUS_SEC: rdata_d = status_sec_q;
        ADDR_ENABLE_PRI: rdata_d = enable_pri_q;
        ADDR_ENABLE_SEC: rdata_d = enable_sec_q;
        default: rdata_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_pri_q <= STATUS_PRI_RESET;
      status_sec_q <= STATUS_SEC_RESET;
    end else begin
      status_pri_q <= status_pri_d;
      status_sec_q <= status_sec_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enable_pri_q <= ENABLE_PRI_RESET;
      enable_sec_q <= ENABLE_SEC_RESET;
    end else begin
      enable_pri_q <= enable_pri_d;
      enable_sec_q <= enable_sec_d;
    end
  end

  // read data is held between reads so the engine may shift it out slowly
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe = status_pri_q[IRQ_BIT];

endmodule // pmu_event_status_mask

// ### tb/pmu_host.sv
`timescale 1ns/10ps
module pmu_host
  import event_status_pkg::*; (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output reg_req_t req
);
  logic [7:0] r;
  initial req = '0;
  // one byte transfer; read data is taken after the answering edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{w, !w, a, d};
    @(negedge clk);
    req = '0;
    r = rdata;
  endtask
endmodule // pmu_host

// ### tb/pmu_chk_asserts.sv
`timescale 1ns/10ps
module pmu_chk
  import event_status_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire primary_src_t primary_src,
  input wire secondary_src_t secondary_src,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic clr = req.wr && req.addr == ADDR_STATUS_PRI && !req.wdata[0];
  wire logic [14:0] src = {primary_src, secondary_src};
  sequence quiet_s; $stable(src) [*3]; endsequence
  pin_low_a: assert property (!irq_pin_out) else $error("pin");
  pin_release_a: assert property (quiet_s ##0 clr |=> !irq_pin_oe) else $error("clr");
  pin_hold_a: assert property (irq_pin_oe && !clr |=> irq_pin_oe) else $error("hold");
  rise_cause_a: assert property ($rose(irq_pin_oe) |-> $past(src, 3) != $past(src, 4))
    else $error("cause");
  flag_read_a: assert property (req.rd && req.addr == ADDR_STATUS_PRI |=>
    rdata[0] == $past(irq_pin_oe)) else $error("flag");
  en_bit0_a: assert property (req.rd && req.addr == ADDR_ENABLE_PRI |=> !rdata[0])
    else $error("bit0");
  rd_hold_a: assert property (!req.rd |=> $stable(rdata)) else $error("rd");
  reset_idle_a: assert property ($rose(rst_n) |-> !irq_pin_oe) else $error("rst");
endmodule // pmu_chk
bind pmu_event_status_mask pmu_chk i_pmu_chk(.clk(clk), .rst_n(rst_n), .primary_src(primary_src),
  .secondary_src(secondary_src), .req(req), .rdata(rdata), .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe));

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import event_status_pkg::*;
  logic clk = 1'b0, rst_n, po, oe;
  primary_src_t ps;
  secondary_src_t ss;
  reg_req_t req;
  logic [7:0] rdata;
  int miscompares, check_count, cyc;
  pmu_event_status_mask i_pmu_event_status_mask(.clk(clk), .rst_n(rst_n), .primary_src(ps),
    .secondary_src(ss), .req(req), .rdata(rdata), .irq_pin_out(po), .irq_pin_oe(oe));
  pmu_host i_pmu_host(.clk(clk), .rdata(rdata), .req(req));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 1000) complete_run(1);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    miscompares += int'(g !== e);
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    i_pmu_host.xfer(1'b0, a, 8'h00);
    chk(i_pmu_host.r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pmu_host.xfer(1'b1, a, d);
  endtask
  // sources change on the falling edge, then n cycles pass
  task automatic drv(input logic [14:0] v, input int n);
    @(negedge clk);
    {ps, ss} = v;
    repeat (n) @(negedge clk);
  endtask
  task automatic t_regs;
    drv(15'h7EFF, 5);
    rd(8'h00, 8'h00);
    rd(8'h10, UNMAPPED_READ);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'hFE);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'hFF);
  endtask
  task automatic t_events;
    drv(15'h0100, 5);
    rd(8'h00, 8'h03);
    wr(8'h00, 8'h00);
    drv(15'h0000, 5);
    rd(8'h00, 8'h01);
    drv(15'h4001, 5);
    rd(8'h00, 8'h81);
    wr(8'h00, 8'h00);
    drv(15'h0000, 5);
    chk({7'h00, oe}, 8'h00);
    // source edge lands in the same cycle as the clear
    drv(15'h0002, 1);
    wr(8'h00, 8'h00);
    rd(8'h01, 8'h02);
  endtask
  // with every enable off, source changes must leave status untouched
  task automatic t_masked;
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h00, 8'h00);
    drv(15'h7EFF, 5);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    chk({7'h00, oe}, 8'h00);
  endtask
  task automatic complete_run(input int extra);
    miscompares += extra;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst_n, ps, ss} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_events;
    t_masked;
    complete_run(0);
  end
endmodule // tb_top
